// *** inc/lta_pkg.sv ***
// Package with the register map, field positions and enumerations of the lookup access engine.
package lta_pkg;
  // Register byte offsets, each register one aligned word.
  localparam logic [15:0] OFF_INDEX0 = 16'h0410;
  localparam logic [15:0] OFF_INDEX1 = 16'h0414;
  localparam logic [15:0] OFF_LOOKUP_CTL = 16'h0418;
  localparam logic [15:0] OFF_STATIC_CTL = 16'h041C;
  localparam logic [15:0] OFF_ENTRY1 = 16'h0420;
  localparam logic [15:0] OFF_ENTRY2 = 16'h0424;
  localparam logic [15:0] OFF_ENTRY3 = 16'h0428;
  localparam logic [15:0] OFF_ENTRY4 = 16'h042C;
  // Byte lane of the entry word 4 register whose read releases a search hit.
  localparam int ENTRY4_TOP_LANE = 3;
  // Writable bits of index register 0; bits 30:23 read as zero.
  localparam logic [31:0] INDEX0_WMASK = 32'h807F_FFFF;
  // Field positions of the lookup access control register.
  localparam int LC_COUNT_LO = 16;
  localparam int LC_KICK = 7;
  localparam int LC_NEXT_READY = 6;
  localparam int LC_READY_OR_END = 5;
  localparam int LC_RSV_LO = 3;
  localparam int LC_DIRECT = 2;
  localparam int LC_OP_LO = 0;
  // Field positions of the static/multicast control register.
  localparam int SC_INDEX_LO = 16;
  localparam int SC_KICK = 7;
  localparam int SC_RSV_LO = 2;
  localparam int SC_TABLE_SEL = 1;
  localparam int SC_READ = 0;
  // Table geometry.
  localparam int COUNT_W = 14;
  localparam int ADDR_W = 12;
  localparam int SLOT_W = 6;
  localparam int STATIC_W = 4;
  localparam logic [11:0] LAST_ADDR = 12'hFFF;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // Dynamic lookup table operation codes.
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_SEARCH = 2'b11
  } lta_op_t;
  // Which table the engine addresses.
  typedef enum logic [1:0] {
    TBL_DYNAMIC = 2'b00,
    TBL_STATIC = 2'b01,
    TBL_MCAST = 2'b10
  } lta_table_t;
  // Engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10,
    ST_HOLD = 2'b11
  } lta_state_t;
endpackage

// *** design/lta_access_engine.sv ***
// Lookup table access engine: control, index and entry registers and the table sequencer.
//
// Behaviour
// - A finished search shows its count of valid entries in control bits 29:16.
// - Writing one to control bit 7 starts the operation; hardware clears it when done.
// - A search hit sets bit 6; reading byte 0x042F clears it.
// - Bit 5 reads one when a hit is ready or the search has ended.
// - Bit 2 one indexes the table directly, zero through the hash.
// - Operation field 1:0: none, write, read, search.
// - The multicast table is indexed by slot pointer bits 21:16.
// - The static table is indexed by slot pointer bits 19:16 only.
// - Bit 7 of the static/multicast control starts its access; hardware clears it.
// - Table chooser bit 1: one multicast table, zero static table.
// - Static/multicast bit 0: one reads, zero writes.
// - Static uses all four entry words; multicast only entry word 2.
// - Dynamic operations take the key from the index registers, data via entry words.
// - Entry words carry the fields of whichever table the operation targets.
// - The hash key joins the group id with the 48-bit address.
// - Direct mode uses index register 1 bits 11:0 as the table address.
`timescale 1ns/1ps
module lta_access_engine (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_tbl_req,
  output logic [1:0] o_tbl_kind,
  output logic o_tbl_write,
  output logic [11:0] o_tbl_addr,
  output logic [127:0] o_tbl_wdata,
  input wire logic i_tbl_ack,
  input wire logic [127:0] i_tbl_rdata,
  input wire logic i_tbl_hit
);

  typedef struct packed {
    logic [31:0] idx0;
    logic [31:0] idx1;
    logic kick;
    logic next_ready;
    logic srch_end;
    logic [1:0] ctl_rsv;
    logic direct;
    lta_pkg::lta_op_t op;
    logic [13:0] count;
    logic sm_kick;
    logic [5:0] sm_index;
    logic [4:0] sm_rsv;
    logic sm_sel;
    logic sm_read;
    logic [0:3][31:0] ent; // Word 1 is the top lane of a table entry.
    lta_pkg::lta_state_t state;
    lta_pkg::lta_table_t kind;
    logic twrite;
    logic treq;
    logic [11:0] taddr;
    logic [127:0] twdata;
    logic [31:0] rdata;
    logic rvalid;
  } lta_regs_t;

  lta_regs_t r_q;
  lta_regs_t r_d;

  // Byte-lane merge of a register write.
  function automatic logic [31:0] lta_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Folds the 7-bit group id and the 48-bit address into a table bucket.
  function automatic logic [11:0] lta_hash(input logic [6:0] filter_group_id, input logic [47:0] mac);
    logic [11:0] h;
    h = {5'h00, filter_group_id};
    for (int k = 0; k < 4; k++) begin
      h = h ^ mac[12*k +: 12];
    end
    return h;
  endfunction

  logic busy;
  logic top_byte_read;
  logic [31:0] wr_word;
  logic [31:0] ctl_word;
  logic [31:0] sm_word;

  assign busy = r_q.kick | r_q.sm_kick;
  assign top_byte_read = i_reg_rd && i_reg_addr == lta_pkg::OFF_ENTRY4 &&
                         i_reg_be[lta_pkg::ENTRY4_TOP_LANE];

  // Read images of the two control registers; reserved fields read back as written, other unused bits read as zero.
  always_comb begin
    ctl_word = lta_pkg::RESET_WORD;
    ctl_word[lta_pkg::LC_COUNT_LO +: lta_pkg::COUNT_W] = r_q.count;
    ctl_word[lta_pkg::LC_KICK] = r_q.kick;
    ctl_word[lta_pkg::LC_NEXT_READY] = r_q.next_ready;
    ctl_word[lta_pkg::LC_READY_OR_END] = r_q.next_ready | r_q.srch_end;
    ctl_word[lta_pkg::LC_RSV_LO +: 2] = r_q.ctl_rsv;
    ctl_word[lta_pkg::LC_DIRECT] = r_q.direct;
    ctl_word[lta_pkg::LC_OP_LO +: 2] = r_q.op;
    sm_word = lta_pkg::RESET_WORD;
    sm_word[lta_pkg::SC_INDEX_LO +: lta_pkg::SLOT_W] = r_q.sm_index;
    sm_word[lta_pkg::SC_KICK] = r_q.sm_kick;
    sm_word[lta_pkg::SC_RSV_LO +: 5] = r_q.sm_rsv;
    sm_word[lta_pkg::SC_TABLE_SEL] = r_q.sm_sel;
    sm_word[lta_pkg::SC_READ] = r_q.sm_read;
  end

  // Next-state logic: register port first, then the table sequencer, whose updates win.
  always_comb begin
    r_d = r_q;
    wr_word = lta_pkg::RESET_WORD;
    r_d.rvalid = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        lta_pkg::OFF_INDEX0: r_d.rdata = r_q.idx0;
        lta_pkg::OFF_INDEX1: r_d.rdata = r_q.idx1;
        lta_pkg::OFF_LOOKUP_CTL: r_d.rdata = ctl_word;
        lta_pkg::OFF_STATIC_CTL: r_d.rdata = sm_word;
        lta_pkg::OFF_ENTRY1: r_d.rdata = r_q.ent[0];
        lta_pkg::OFF_ENTRY2: r_d.rdata = r_q.ent[1];
        lta_pkg::OFF_ENTRY3: r_d.rdata = r_q.ent[2];
        lta_pkg::OFF_ENTRY4: r_d.rdata = r_q.ent[3];
        default: r_d.rdata = lta_pkg::RESET_WORD;
      endcase
    end
    // Reading the top entry byte hands the hit back to the search.
    if (top_byte_read) begin
      r_d.next_ready = 1'b0;
    end
    // Control writes are ignored while an operation runs, so its index stays stable.
    if (i_reg_wr) begin
      case (i_reg_addr)
        lta_pkg::OFF_INDEX0: begin
          if (!busy) begin
            r_d.idx0 = lta_merge(r_q.idx0, i_reg_wdata, i_reg_be) & lta_pkg::INDEX0_WMASK;
          end
        end
        lta_pkg::OFF_INDEX1: begin
          if (!busy) begin
            r_d.idx1 = lta_merge(r_q.idx1, i_reg_wdata, i_reg_be);
          end
        end
        lta_pkg::OFF_LOOKUP_CTL: begin
          if (!busy) begin
            wr_word = lta_merge(ctl_word, i_reg_wdata, i_reg_be);
            r_d.kick = wr_word[lta_pkg::LC_KICK];
            r_d.ctl_rsv = wr_word[lta_pkg::LC_RSV_LO +: 2];
            r_d.direct = wr_word[lta_pkg::LC_DIRECT];
            r_d.op = lta_pkg::lta_op_t'(wr_word[lta_pkg::LC_OP_LO +: 2]);
          end
        end
        lta_pkg::OFF_STATIC_CTL: begin
          if (!busy) begin
            wr_word = lta_merge(sm_word, i_reg_wdata, i_reg_be);
            r_d.sm_index = wr_word[lta_pkg::SC_INDEX_LO +: lta_pkg::SLOT_W];
            r_d.sm_kick = wr_word[lta_pkg::SC_KICK];
            r_d.sm_rsv = wr_word[lta_pkg::SC_RSV_LO +: 5];
            r_d.sm_sel = wr_word[lta_pkg::SC_TABLE_SEL];
            r_d.sm_read = wr_word[lta_pkg::SC_READ];
          end
        end
        lta_pkg::OFF_ENTRY1: r_d.ent[0] = lta_merge(r_q.ent[0], i_reg_wdata, i_reg_be);
        lta_pkg::OFF_ENTRY2: r_d.ent[1] = lta_merge(r_q.ent[1], i_reg_wdata, i_reg_be);
        lta_pkg::OFF_ENTRY3: r_d.ent[2] = lta_merge(r_q.ent[2], i_reg_wdata, i_reg_be);
        lta_pkg::OFF_ENTRY4: r_d.ent[3] = lta_merge(r_q.ent[3], i_reg_wdata, i_reg_be);
        default: r_d.rdata = r_d.rdata;
      endcase
    end
    // Sequencer. Only the dynamic kick wins if both are set in one write.
    case (r_q.state)
      lta_pkg::ST_IDLE: begin
        if (r_q.kick) begin
          r_d.kind = lta_pkg::TBL_DYNAMIC;
          r_d.twrite = r_q.op == lta_pkg::OP_WRITE;
          if (r_q.direct) begin
            r_d.taddr = r_q.idx1[lta_pkg::ADDR_W-1:0];
          end else begin
            r_d.taddr = lta_hash(r_q.idx0[22:16], {r_q.idx0[15:0], r_q.idx1});
          end
          case (r_q.op)
            lta_pkg::OP_NONE: r_d.kick = 1'b0;
            lta_pkg::OP_SEARCH: begin
              r_d.taddr = {lta_pkg::ADDR_W{1'b0}};
              r_d.count = {lta_pkg::COUNT_W{1'b0}};
              r_d.srch_end = 1'b0;
              r_d.next_ready = 1'b0;
              r_d.state = lta_pkg::ST_ISSUE;
            end
            default: r_d.state = lta_pkg::ST_ISSUE;
          endcase
        end else if (r_q.sm_kick) begin
          r_d.twrite = !r_q.sm_read;
          if (r_q.sm_sel) begin
            r_d.kind = lta_pkg::TBL_MCAST;
            r_d.taddr = {6'h00, r_q.sm_index};
          end else begin
            r_d.kind = lta_pkg::TBL_STATIC;
            r_d.taddr = {8'h00, r_q.sm_index[lta_pkg::STATIC_W-1:0]};
          end
          r_d.state = lta_pkg::ST_ISSUE;
        end
      end
      lta_pkg::ST_ISSUE: begin
        // Write data is frozen here, so later entry writes cannot disturb a pending request.
        r_d.twdata = r_q.ent;
        if (r_q.kind == lta_pkg::TBL_MCAST) begin
          r_d.twdata = {32'h0000_0000, r_q.ent[1], 64'h0000_0000_0000_0000};
        end
        r_d.treq = 1'b1;
        r_d.state = lta_pkg::ST_WAIT;
      end
      lta_pkg::ST_WAIT: begin
        if (i_tbl_ack) begin
          r_d.treq = 1'b0;
          r_d.state = lta_pkg::ST_IDLE;
          if (r_q.kind == lta_pkg::TBL_DYNAMIC && r_q.op == lta_pkg::OP_SEARCH) begin
            if (i_tbl_hit) begin
              r_d.ent = i_tbl_rdata;
              r_d.next_ready = 1'b1;
              r_d.count = r_q.count + 14'h0001;
              r_d.state = lta_pkg::ST_HOLD;
            end else if (r_q.taddr == lta_pkg::LAST_ADDR) begin
              r_d.kick = 1'b0;
              r_d.srch_end = 1'b1;
            end else begin
              r_d.taddr = r_q.taddr + 12'h001;
              r_d.state = lta_pkg::ST_ISSUE;
            end
          end else begin
            // The mcast table only ever moves entry word 2.
            if (!r_q.twrite && r_q.kind == lta_pkg::TBL_MCAST) begin
              r_d.ent[1] = i_tbl_rdata[95:64];
            end else if (!r_q.twrite) begin
              r_d.ent = i_tbl_rdata;
            end
            if (r_q.kind == lta_pkg::TBL_DYNAMIC) begin
              r_d.kick = 1'b0;
            end else begin
              r_d.sm_kick = 1'b0;
            end
          end
        end
      end
      lta_pkg::ST_HOLD: begin
        // Wait for software to take the hit before the walk moves on.
        if (!r_q.next_ready) begin
          if (r_q.taddr == lta_pkg::LAST_ADDR) begin
            r_d.kick = 1'b0;
            r_d.srch_end = 1'b1;
            r_d.state = lta_pkg::ST_IDLE;
          end else begin
            r_d.taddr = r_q.taddr + 12'h001;
            r_d.state = lta_pkg::ST_ISSUE;
          end
        end
      end
      default: r_d.state = lta_pkg::ST_IDLE;
    endcase
  end

  // All state in one register; synchronous reset to zero.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Every table and register output is a field of the state register.
  assign o_tbl_wdata = r_q.twdata;
  assign o_reg_rdata = r_q.rdata;
  assign o_reg_rvalid = r_q.rvalid;
  assign o_tbl_req = r_q.treq;
  assign o_tbl_kind = r_q.kind;
  assign o_tbl_write = r_q.twrite;
  assign o_tbl_addr = r_q.taddr;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_nop_kick_clears: assert property (
    r_q.state == lta_pkg::ST_IDLE && r_q.kick && r_q.op == lta_pkg::OP_NONE
      |=> !r_q.kick && !o_tbl_req ##1 !o_tbl_req)
    else $error("no-op start did not finish quietly");
  a_kick_done_idle: assert property (
    $fell(r_q.kick) |-> r_q.state == lta_pkg::ST_IDLE && !o_tbl_req)
    else $error("kick cleared while the engine was busy");
  a_hit_read_clear: assert property (
    r_q.next_ready && top_byte_read |=> !r_q.next_ready)
    else $error("top byte read did not clear next ready");
  a_hit_sets_count: assert property (
    r_q.state == lta_pkg::ST_WAIT && i_tbl_ack && i_tbl_hit && r_q.op == lta_pkg::OP_SEARCH
      && r_q.kind == lta_pkg::TBL_DYNAMIC
      |=> r_q.next_ready && r_q.count == $past(r_q.count) + 14'h0001)
    else $error("search hit not recorded");
  a_ready_or_end_bit: assert property (
    i_reg_rd && i_reg_addr == lta_pkg::OFF_LOOKUP_CTL
      |=> o_reg_rdata[5] == ($past(r_q.next_ready) | $past(r_q.srch_end)))
    else $error("ready-or-end bit wrong");
  a_direct_index: assert property (
    r_q.state == lta_pkg::ST_IDLE && r_q.kick && r_q.direct && r_q.op != lta_pkg::OP_SEARCH
      && r_q.op != lta_pkg::OP_NONE |-> ##2 o_tbl_req && o_tbl_addr == r_q.idx1[11:0])
    else $error("direct index not used");
  a_static_index: assert property (
    o_tbl_req && o_tbl_kind == lta_pkg::TBL_STATIC |-> o_tbl_addr == {8'h00, r_q.sm_index[3:0]})
    else $error("static index wrong");
  a_mcast_index: assert property (
    o_tbl_req && o_tbl_kind == lta_pkg::TBL_MCAST |-> o_tbl_addr == {6'h00, r_q.sm_index})
    else $error("multicast index wrong");
  a_sm_direction: assert property (
    o_tbl_req && o_tbl_kind != lta_pkg::TBL_DYNAMIC |-> o_tbl_write == !r_q.sm_read)
    else $error("static access direction wrong");
  a_mcast_word_only: assert property (
    r_q.state == lta_pkg::ST_WAIT && i_tbl_ack && o_tbl_kind == lta_pkg::TBL_MCAST
      && !i_reg_wr |=> $stable(r_q.ent[0]) && $stable(r_q.ent[2]) && $stable(r_q.ent[3]))
    else $error("multicast access touched other entry words");

  c_search_hit: cover property (r_q.next_ready && top_byte_read);
  c_search_end: cover property ($rose(r_q.srch_end));
  c_static_read: cover property ($fell(r_q.sm_kick) && r_q.sm_read && !r_q.sm_sel);
  c_mcast_write: cover property ($fell(r_q.sm_kick) && !r_q.sm_read && r_q.sm_sel);

endmodule

// *** test/tb_top.sv ***
// Self-checking testbench for the lookup table access engine.
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;
  logic req;
  logic [1:0] kind;
  logic twr;
  logic [11:0] taddr;
  logic [127:0] twdata;
  logic ack;
  logic [127:0] trdata;
  logic hit;
  logic [4095:0] hit_map;
  logic [1:0] l_kind;
  logic l_wr;
  logic [11:0] l_addr;
  logic [127:0] l_wdata;
  int stall = 0;
  int n_req = 0;
  int cycles = 0;
  int n_mismatch = 0;
  int check_count = 0;

  lta_access_engine i_dut (
    .i_ref_clk(clk),
    .i_reset(rst),
    .i_reg_wr(wr),
    .i_reg_rd(rd),
    .i_reg_addr(addr),
    .i_reg_be(be),
    .i_reg_wdata(wdata),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .o_tbl_req(req),
    .o_tbl_kind(kind),
    .o_tbl_write(twr),
    .o_tbl_addr(taddr),
    .o_tbl_wdata(twdata),
    .i_tbl_ack(ack),
    .i_tbl_rdata(trdata),
    .i_tbl_hit(hit)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Table side answers after a random stall; data lines scramble once the answer is gone.
  always @(negedge clk) begin
    if (ack) begin
      ack <= 1'h0;
      trdata <= ~trdata;
      hit <= ~hit;
    end else if (req && stall != 0) begin
      stall <= stall - 1;
    end else if (req) begin
      ack <= 1'h1;
      stall <= $urandom_range(3);
      n_req <= n_req + 1;
      l_kind <= kind;
      l_wr <= twr;
      l_addr <= taddr;
      l_wdata <= twdata;
      trdata <= {taddr, 20'hC3A51, taddr, 20'hC3A52, taddr, 20'hC3A53, taddr, 20'hC3A54};
      hit <= hit_map[taddr];
    end
  end

  // A hang is cut short well above the longest walk of the table.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'h1;
    addr = a;
    wdata = d;
    be = 4'hF;
    @(negedge clk);
    wr = 1'h0;
    wdata = $urandom;
  endtask

  // The answer stands for one cycle, so it is looked at in the cycle after the taking edge.
  task automatic reg_rd(input logic [15:0] a, input logic [3:0] b, output logic [31:0] d);
    @(negedge clk);
    rd = 1'h1;
    addr = a;
    be = b;
    @(negedge clk);
    rd = 1'h0;
    chk("read answer", 1'h1, rvalid);
    d = rdata;
  endtask

  task automatic wait_done(input logic [15:0] a);
    logic [31:0] v;
    v = 32'hFFFFFFFF;
    for (int i = 0; i < 40 && v[7] !== 1'h0; i++) reg_rd(a, 4'hF, v);
    chk("kick clears", 1'h0, v[7]);
  endtask

  // The chosen hash folds the group id and four 12-bit slices of the address.
  function automatic logic [11:0] hash_of(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] m;
    m = {a[15:0], b};
    return {5'h00, a[22:16]} ^ m[47:36] ^ m[35:24] ^ m[23:12] ^ m[11:0];
  endfunction

  initial begin
    logic [31:0] v;
    logic [31:0] w4;
    logic [31:0] i0;
    logic [31:0] i1;
    logic [31:0] e [4];
    logic [15:0] offs [4];
    logic [11:0] xa;
    logic [5:0] slot;
    logic [1:0] op;
    int nh;
    int got;
    int last;
    rst = 1'h1;
    wr = 1'h0;
    rd = 1'h0;
    addr = 16'h0000;
    be = 4'h0;
    wdata = 32'h0;
    ack = 1'h0;
    hit = 1'h0;
    trdata = 128'h0;
    hit_map = '0;
    v = $urandom(64);
    repeat (2) @(negedge clk);
    rst = 1'h0;
    // Reset image of both controls, an entry word and an unmapped word.
    offs = '{lta_pkg::OFF_LOOKUP_CTL, lta_pkg::OFF_STATIC_CTL, lta_pkg::OFF_ENTRY2, 16'h0400};
    foreach (offs[k]) begin
      reg_rd(offs[k], 4'hF, v);
      chk("reset word", 32'h0, v);
    end
    // Dynamic write, read and no-op, through the hash and then direct.
    for (int m = 0; m < 2; m++) begin
      for (int k = 1; k < 4; k++) begin
        op = 2'(k % 3);
        i0 = $urandom & lta_pkg::INDEX0_WMASK;
        i1 = $urandom;
        reg_wr(lta_pkg::OFF_INDEX0, i0);
        reg_wr(lta_pkg::OFF_INDEX1, i1);
        for (int w = 0; w < 4; w++) begin
          e[w] = $urandom;
          reg_wr(lta_pkg::OFF_ENTRY1 + 16'(4 * w), e[w]);
        end
        xa = (m == 1) ? i1[11:0] : hash_of(i0, i1);
        nh = n_req;
        reg_wr(lta_pkg::OFF_LOOKUP_CTL, {24'h0, 1'h1, 4'h0, 1'(m), op});
        wait_done(lta_pkg::OFF_LOOKUP_CTL);
        if (op == 2'h0) begin
          chk("no-op requests", 1'h0, n_req != nh);
        end else begin
          chk("table kind", 2'h0, l_kind);
          chk("write flag", op == 2'h1, l_wr);
          chk("table address", xa, l_addr);
        end
        if (op == 2'h1) begin
          chk("write entry", {e[0], e[1], e[2], e[3]}, l_wdata);
        end
        if (op == 2'h2) begin
          reg_rd(lta_pkg::OFF_ENTRY1, 4'hF, v);
          chk("read entry", {xa, 20'hC3A51}, v);
        end
      end
    end
    // Static and multicast tables, each written and read, with a six-bit slot.
    for (int t = 0; t < 4; t++) begin
      slot = 6'($urandom);
      for (int w = 0; w < 4; w++) begin
        e[w] = $urandom;
        reg_wr(lta_pkg::OFF_ENTRY1 + 16'(4 * w), e[w]);
      end
      xa = t[1] ? {6'h00, slot} : {8'h00, slot[3:0]};
      reg_wr(lta_pkg::OFF_STATIC_CTL, {10'h0, slot, 8'h00, 1'h1, 5'h00, 2'(t)});
      wait_done(lta_pkg::OFF_STATIC_CTL);
      chk("static kind", t[1] ? 2'h2 : 2'h1, l_kind);
      chk("static address", xa, l_addr);
      chk("static write", !t[0], l_wr);
      if (!t[0]) begin
        chk("static data", t[1] ? {32'h0, e[1], 64'h0} : {e[0], e[1], e[2], e[3]},
            l_wdata);
      end else begin
        reg_rd(lta_pkg::OFF_ENTRY2, 4'hF, v);
        chk("static read", {xa, 20'hC3A52}, v);
      end
    end
    // Search with hits at both ends of the table and back to back.
    hit_map[0] = 1'h1;
    hit_map[1] = 1'h1;
    hit_map[4095] = 1'h1;
    repeat (5) hit_map[$urandom_range(4094, 2)] = 1'h1;
    nh = $countones(hit_map);
    got = 0;
    last = -1;
    // Software dump of the table: poll for hits, take each one by reading the top byte.
    reg_wr(lta_pkg::OFF_LOOKUP_CTL, 32'h0000_0083);
    do begin
      v = 32'h0000_0080;
      for (int p = 0; p < 20000 && v[7] === 1'h1 && v[6] !== 1'h1; p++) begin
        reg_rd(lta_pkg::OFF_LOOKUP_CTL, 4'hF, v);
      end
      if (v[6] === 1'h1) begin
        chk("hit or end", 1'h1, v[5]);
        reg_rd(lta_pkg::OFF_ENTRY4, 4'h8, w4);
        chk("hit slot", 1'h1, hit_map[w4[31:20]] && int'(w4[31:20]) > last);
        last = int'(w4[31:20]);
        got++;
      end
    end while (v[7] === 1'h1 && got <= nh);
    chk("hits seen", nh, got);
    chk("hit count", 14'(nh), v[29:16]);
    chk("search ended", 1'h1, v[5]);
    give_verdict();
  end
endmodule
